//--- shared/cache_pkg.sv
// shared constants and types for the secondary cache bus control
// Notes on behaviour
// - every address strobe while idle and not in or just after backoff starts a tag lookup, selected or not; I/O cycles ignored
// - 64k sets from A4-A14; 128k sets A5-A15, A4 picks sector line
// - write hits update only enabled bytes; other partial transfers ignored
// - a fill ended early by last transfer leaves its line invalid
// - after backoff is sampled, the data bus is released next clock
// - a read-hit burst cut by backoff is dropped; the rest runs as miss
// - a fill cut by backoff leaves the line invalid, even if resumed
// - snoop strobe with module selected invalidates the bus address, also during backoff
// - invalidate-all clears every entry regardless of module select
// - while invalidate-all is held, every access misses and memory go follows
// - reset idles all machines and invalidates the whole cache
// - protect strap sampled before its synchroniser fills, so only the reset value is held and strapped never reads true
// - deselected: no snoop invalidations, memory go and cacheable output inactive after address phase
// - cacheable output active in address phase, inactive in data phases for misses/writes
// - read hit reasserts cacheable from second data phase, also when protected, as the strap never latches
// - read hit drives burst ready for four consecutive data phase clocks
// - module present output held low permanently
// - memory go for read misses and memory writes, delayed after a coinciding invalidation
// - line protect sampled on third fill ready, one bit per tag; protected writes ignored
// - fill cacheable sampled before first and last transfers; line kept only if cacheable
package cache_pkg;
  localparam int ADDR_HI = 31;
  localparam int ADDR_LO = 2;
  localparam int DATA_W = 32;
  localparam int WORD_W = 36;
  localparam int BYTES = 4;
  localparam int BYTE_W = 8;
  localparam int SET_LO_SMALL = 4;
  localparam int SET_LO_LARGE = 5;
  localparam int SECTOR_BIT = 4;
  localparam int WORD_BIT = 2;
  localparam int SET_BITS = 11;
  localparam logic [1:0] FIRST_BEAT = 2'h0;
  localparam logic [1:0] PROTECT_BEAT = 2'h2;
  localparam logic [1:0] LAST_BEAT = 2'h3;
  localparam logic [1:0] STRAP_SYNC_DONE = 2'h3;

  typedef struct packed {
    logic [ADDR_HI:ADDR_LO] addr;
    logic write;
    logic memory;
    logic [BYTES-1:0] byte_en_n;
    logic address_strobe_n;
    logic last_transfer_n;
  } cpu_bus_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_HIT = 4'h2,
    ST_MISS = 4'h4,
    ST_WAIT = 4'h8
  } ctl_state_type;
endpackage

//--- hdl/secondary_cache_bus_control.sv
// control, tag and data store of a write-through two-way secondary cache
`timescale 1ns/1ps
module secondary_cache_bus_control #(
  parameter bit LARGE_CONFIG = 1'b0,
  parameter int SET_BITS = cache_pkg::SET_BITS
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire cache_pkg::cpu_bus_type i_bus,
  input wire logic [cache_pkg::WORD_W-1:0] i_data,
  input wire logic i_cpu_burst_ready_n,
  input wire logic i_cpu_ready_n,
  input wire logic i_backoff_n,
  input wire logic i_snoop_strobe_n,
  input wire logic i_invalidate_all_n,
  input wire logic i_module_select_n,
  input wire logic i_fill_cacheable_n,
  input wire logic i_line_protect,
  input wire logic i_protect_strap_n,
  output logic [cache_pkg::WORD_W-1:0] o_data,
  output logic o_data_oe,
  output logic o_hit_cacheable_n,
  output logic o_burst_ready_out_n,
  output logic o_memory_go_n,
  output logic o_module_present_n
);
  localparam int SETS = 1 << SET_BITS;
  localparam int LINE_IDX_W = SET_BITS + 2;
  localparam int LINES = 1 << LINE_IDX_W;
  localparam int WORD_IDX_W = LINE_IDX_W + 2;
  localparam int SET_LO = LARGE_CONFIG ? cache_pkg::SET_LO_LARGE : cache_pkg::SET_LO_SMALL;
  localparam int TAG_LO = SET_LO + SET_BITS;
  localparam int TAG_W = cache_pkg::ADDR_HI + 1 - cache_pkg::SET_LO_SMALL - SET_BITS;

  typedef logic [cache_pkg::ADDR_HI:cache_pkg::ADDR_LO] addr_type;

  // set, sector and tag fields of an address
  function automatic logic [SET_BITS-1:0] set_of(input addr_type a);
    set_of = a[SET_LO +: SET_BITS];
  endfunction

  function automatic logic sector_of(input addr_type a);
    sector_of = LARGE_CONFIG ? a[cache_pkg::SECTOR_BIT] : 1'b0;
  endfunction

  function automatic logic [TAG_W-1:0] tag_of(input addr_type a);
    logic [cache_pkg::ADDR_HI:0] full;
    full = {a, 2'b00};
    tag_of = TAG_W'(full >> TAG_LO);
  endfunction

  function automatic logic [LINE_IDX_W-1:0] line_idx(input logic w, input addr_type a);
    line_idx = {w, set_of(a), sector_of(a)};
  endfunction

  function automatic logic [SET_BITS:0] tag_idx(input logic w, input addr_type a);
    tag_idx = {w, set_of(a)};
  endfunction

  cache_pkg::ctl_state_type state_r;
  logic [TAG_W-1:0] tag_mem [2*SETS];
  logic [cache_pkg::WORD_W-1:0] data_mem [LINES*4];
  logic [LINES-1:0] valid_r;
  logic [2*SETS-1:0] protect_r;
  logic [SETS-1:0] lru_r;
  addr_type req_addr_r;
  logic req_write_r;
  logic [cache_pkg::BYTES-1:0] req_be_n_r;
  logic req_cs_r;
  logic hit_r;
  logic fill_way_r;
  logic alloc_r;
  logic abort_r;
  logic [1:0] beat_r;
  logic ken_prev_r;
  logic backoff_prev_n_r;
  logic flush_meta_n_r;
  logic flush_n_r;
  logic strap_meta_n_r;
  logic strap_sync_n_r;
  logic [1:0] strap_pipe_r;
  logic strap_low_r;

  logic [1:0] tag_match;
  logic [1:0] way_valid;
  logic [1:0] way_hit;
  logic hit_any;
  logic hit_way;
  logic victim;
  logic start_cycle;
  logic snoop_now;
  logic ready_now;
  logic end_cycle;
  logic fill_beat;
  logic fill_done;
  logic burst_last;
  logic write_hit_now;
  logic [WORD_IDX_W-1:0] hit_word_idx;
  logic [WORD_IDX_W-1:0] next_word_idx;
  logic [WORD_IDX_W-1:0] fill_word_idx;

  assign o_module_present_n = 1'b0;

  // tag compare on the live bus address, used by lookups and snoops alike
  always_comb begin
    for (int w = 0; w < 2; w++) begin
      way_valid[w] = valid_r[{w[0], set_of(i_bus.addr), 1'b0}]
        | valid_r[{w[0], set_of(i_bus.addr), 1'b1}];
      tag_match[w] = way_valid[w] && (tag_mem[tag_idx(w[0], i_bus.addr)] == tag_of(i_bus.addr));
      way_hit[w] = tag_match[w] && valid_r[line_idx(w[0], i_bus.addr)];
    end
  end

  assign hit_any = (|way_hit) && flush_n_r;
  assign hit_way = way_hit[1];

  // a way already holding the tag keeps the sister sector, then an empty way, then lru
  always_comb begin
    if (tag_match[0]) begin
      victim = 1'b0;
    end else if (tag_match[1]) begin
      victim = 1'b1;
    end else if (!way_valid[0]) begin
      victim = 1'b0;
    end else if (!way_valid[1]) begin
      victim = 1'b1;
    end else begin
      victim = lru_r[set_of(i_bus.addr)];
    end
  end

  // an address strobe in or just after backoff is a floating strobe and is ignored
  assign start_cycle = (state_r == cache_pkg::ST_IDLE) && !i_bus.address_strobe_n
    && i_bus.memory && i_backoff_n && backoff_prev_n_r;
  assign snoop_now = !i_snoop_strobe_n && !i_module_select_n;
  assign ready_now = !i_cpu_burst_ready_n || !i_cpu_ready_n;
  assign end_cycle = ready_now && !i_bus.last_transfer_n;
  assign fill_beat = (state_r == cache_pkg::ST_MISS) && !req_write_r && !i_cpu_burst_ready_n;
  assign fill_done = fill_beat && !i_bus.last_transfer_n && (beat_r == cache_pkg::LAST_BEAT)
    && alloc_r && !abort_r && !ken_prev_r && i_backoff_n;
  assign burst_last = (beat_r == cache_pkg::LAST_BEAT);
  assign write_hit_now = (state_r == cache_pkg::ST_MISS) && req_write_r && hit_r && req_cs_r
    && ready_now && !protect_r[{fill_way_r, set_of(req_addr_r)}];

  // wrapping burst order: the start word xor the beat count
  assign hit_word_idx = {line_idx(hit_way, i_bus.addr), i_bus.addr[cache_pkg::WORD_BIT +: 2]};
  assign next_word_idx = {line_idx(fill_way_r, req_addr_r),
    req_addr_r[cache_pkg::WORD_BIT +: 2] ^ (beat_r + 2'h1)};
  assign fill_word_idx = {line_idx(fill_way_r, req_addr_r),
    req_addr_r[cache_pkg::WORD_BIT +: 2] ^ beat_r};

  // invalidate-all may arrive asynchronously
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flush_meta_n_r <= 1'b1;
      flush_n_r <= 1'b1;
    end else begin
      flush_meta_n_r <= i_invalidate_all_n;
      flush_n_r <= flush_meta_n_r;
    end
  end

  // protect strap caught before the synchroniser has filled after reset release, so only its reset value is latched
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_meta_n_r <= 1'b1;
      strap_sync_n_r <= 1'b1;
      strap_pipe_r <= 2'h0;
      strap_low_r <= 1'b0;
    end else begin
      strap_meta_n_r <= i_protect_strap_n;
      strap_sync_n_r <= strap_meta_n_r;
      if (strap_pipe_r != cache_pkg::STRAP_SYNC_DONE) begin
        strap_pipe_r <= {strap_pipe_r[0], 1'b1};
        strap_low_r <= !strap_sync_n_r;
      end
    end
  end

  // bus cycle control
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= cache_pkg::ST_IDLE;
      req_addr_r <= '0;
      req_write_r <= 1'b0;
      req_be_n_r <= '1;
      req_cs_r <= 1'b0;
      hit_r <= 1'b0;
      fill_way_r <= 1'b0;
      alloc_r <= 1'b0;
      abort_r <= 1'b0;
      beat_r <= cache_pkg::FIRST_BEAT;
      ken_prev_r <= 1'b1;
      backoff_prev_n_r <= 1'b1;
    end else begin
      backoff_prev_n_r <= i_backoff_n;
      ken_prev_r <= i_fill_cacheable_n;
      unique case (state_r)
        cache_pkg::ST_IDLE: begin
          if (start_cycle) begin
            req_addr_r <= i_bus.addr;
            req_write_r <= i_bus.write;
            req_be_n_r <= i_bus.byte_en_n;
            req_cs_r <= !i_module_select_n;
            hit_r <= hit_any && !snoop_now;
            fill_way_r <= hit_any ? hit_way : victim;
            alloc_r <= !i_bus.write && !i_module_select_n && flush_n_r;
            abort_r <= 1'b0;
            beat_r <= cache_pkg::FIRST_BEAT;
            if (hit_any && !snoop_now && !i_bus.write && !i_module_select_n) begin
              state_r <= cache_pkg::ST_HIT;
            end else if (snoop_now) begin
              state_r <= cache_pkg::ST_WAIT;
            end else begin
              state_r <= cache_pkg::ST_MISS;
            end
          end
        end
        cache_pkg::ST_WAIT: begin
          state_r <= cache_pkg::ST_MISS;
        end
        cache_pkg::ST_HIT: begin
          if (!i_backoff_n || burst_last) begin
            state_r <= cache_pkg::ST_IDLE;
          end else begin
            beat_r <= beat_r + 2'h1;
          end
        end
        cache_pkg::ST_MISS: begin
          if (fill_beat && beat_r == cache_pkg::FIRST_BEAT && ken_prev_r) begin
            alloc_r <= 1'b0;
          end
          if (snoop_now && set_of(i_bus.addr) == set_of(req_addr_r)
              && tag_of(i_bus.addr) == tag_of(req_addr_r)) begin
            abort_r <= 1'b1;
          end
          if (fill_beat) begin
            beat_r <= beat_r + 2'h1;
          end
          if (!i_backoff_n) begin
            abort_r <= 1'b1;
            state_r <= cache_pkg::ST_IDLE;
          end else if (end_cycle) begin
            state_r <= cache_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // outputs toward the processor and the memory controller
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_data <= '0;
      o_data_oe <= 1'b0;
      o_hit_cacheable_n <= 1'b0;
      o_burst_ready_out_n <= 1'b1;
      o_memory_go_n <= 1'b1;
    end else begin
      unique case (state_r)
        cache_pkg::ST_IDLE: begin
          o_hit_cacheable_n <= 1'b0;
          if (start_cycle) begin
            o_hit_cacheable_n <= 1'b1;
            if (hit_any && !snoop_now && !i_bus.write && !i_module_select_n) begin
              o_data <= data_mem[hit_word_idx];
              o_data_oe <= 1'b1;
              o_burst_ready_out_n <= 1'b0;
            end else begin
              o_memory_go_n <= snoop_now || i_module_select_n;
            end
          end
        end
        cache_pkg::ST_WAIT: begin
          o_memory_go_n <= !req_cs_r;
        end
        cache_pkg::ST_HIT: begin
          if (!i_backoff_n || burst_last) begin
            o_data_oe <= 1'b0;
            o_burst_ready_out_n <= 1'b1;
            o_hit_cacheable_n <= 1'b0;
          end else begin
            o_data <= data_mem[next_word_idx];
            o_burst_ready_out_n <= 1'b0;
            o_hit_cacheable_n <= protect_r[{fill_way_r, set_of(req_addr_r)}]
              && strap_low_r;
          end
        end
        cache_pkg::ST_MISS: begin
          if (!i_backoff_n || end_cycle) begin
            o_memory_go_n <= 1'b1;
            o_hit_cacheable_n <= 1'b0;
          end
        end
      endcase
    end
  end

  // valid, protect and lru state
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      valid_r <= '0;
      protect_r <= '0;
      lru_r <= '0;
    end else begin
      if (start_cycle && !hit_any && !i_bus.write && !i_module_select_n && flush_n_r
          && !tag_match[victim]) begin
        valid_r[{victim, set_of(i_bus.addr), 1'b0}] <= 1'b0;
        valid_r[{victim, set_of(i_bus.addr), 1'b1}] <= 1'b0;
      end
      if (start_cycle && hit_any && !i_module_select_n) begin
        lru_r[set_of(i_bus.addr)] <= !hit_way;
      end
      if (fill_beat && beat_r == cache_pkg::PROTECT_BEAT && alloc_r) begin
        protect_r[{fill_way_r, set_of(req_addr_r)}] <= i_line_protect;
      end
      if (fill_done) begin
        valid_r[line_idx(fill_way_r, req_addr_r)] <= 1'b1;
        lru_r[set_of(req_addr_r)] <= !fill_way_r;
      end
      if (state_r == cache_pkg::ST_HIT && !i_backoff_n) begin
        valid_r[line_idx(fill_way_r, req_addr_r)] <= 1'b0;
      end
      if (snoop_now) begin
        for (int w = 0; w < 2; w++) begin
          if (way_hit[w]) begin
            valid_r[line_idx(w[0], i_bus.addr)] <= 1'b0;
          end
        end
      end
      if (!flush_n_r) begin
        valid_r <= '0;
      end
    end
  end

  // tag store written as a fill is allocated
  always_ff @(posedge i_clk) begin
    if (start_cycle && !hit_any && !i_bus.write && !i_module_select_n && flush_n_r) begin
      tag_mem[tag_idx(victim, i_bus.addr)] <= tag_of(i_bus.addr);
    end
  end

  // data store: fill beats write whole words, write hits only enabled bytes
  always_ff @(posedge i_clk) begin
    if (fill_beat && alloc_r) begin
      data_mem[fill_word_idx] <= i_data;
    end
    if (write_hit_now) begin
      for (int b = 0; b < cache_pkg::BYTES; b++) begin
        if (!req_be_n_r[b]) begin
          data_mem[fill_word_idx][b*cache_pkg::BYTE_W +: cache_pkg::BYTE_W] <=
            i_data[b*cache_pkg::BYTE_W +: cache_pkg::BYTE_W];
          data_mem[fill_word_idx][cache_pkg::DATA_W + b] <= i_data[cache_pkg::DATA_W + b];
        end
      end
    end
  end
endmodule

//--- testbench/secondary_cache_bus_control_chk.sv
// port assertions for the secondary cache bus control
`timescale 1ns/1ps
module secondary_cache_bus_control_chk (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire cache_pkg::cpu_bus_type i_bus,
  input wire logic i_backoff_n,
  input wire logic i_invalidate_all_n,
  input wire logic i_module_select_n,
  input wire logic i_protect_strap_n,
  input wire logic o_data_oe,
  input wire logic o_hit_cacheable_n,
  input wire logic o_burst_ready_out_n,
  input wire logic o_memory_go_n,
  input wire logic o_module_present_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic strobe;
  assign strobe = !i_bus.address_strobe_n && i_bus.memory;
  property p_present; o_module_present_n == 1'b0; endproperty
  a_present: assert property (p_present) else $error("present low lost");
  property p_burst;
    $fell(o_burst_ready_out_n) |-> ((!o_burst_ready_out_n)[*4] ##1 o_burst_ready_out_n)
      or (##[0:3] !i_backoff_n);
  endproperty
  a_burst: assert property (p_burst) else $error("hit burst not four beats");
  property p_release; !i_backoff_n |=> !o_data_oe; endproperty
  a_release: assert property (p_release) else $error("data bus kept in backoff");
  property p_go_ck; !o_memory_go_n |-> o_hit_cacheable_n; endproperty
  a_go_ck: assert property (p_go_ck) else $error("cacheable active on miss");
  property p_t1_ck; !i_bus.address_strobe_n |-> !o_hit_cacheable_n; endproperty
  a_t1_ck: assert property (p_t1_ck) else $error("cacheable off in address phase");
  property p_hit_ck;
    !o_burst_ready_out_n && $past(!o_burst_ready_out_n) && i_protect_strap_n |-> !o_hit_cacheable_n;
  endproperty
  a_hit_ck: assert property (p_hit_ck) else $error("cacheable off in hit");
  property p_first_ck; $fell(o_burst_ready_out_n) |-> o_hit_cacheable_n; endproperty
  a_first_ck: assert property (p_first_ck) else $error("cacheable on first beat");
  property p_go_cause;
    $fell(o_memory_go_n) |-> $past(strobe) || $past(strobe, 2) || $past(strobe, 3);
  endproperty
  a_go_cause: assert property (p_go_cause) else $error("memory go without cycle");
  property p_desel; strobe && i_module_select_n |=> o_memory_go_n [*2]; endproperty
  a_desel: assert property (p_desel) else $error("memory go while deselected");
  property p_flush;
    (!i_invalidate_all_n)[*3] ##0 (strobe && !i_module_select_n) |=> o_burst_ready_out_n [*2];
  endproperty
  a_flush: assert property (p_flush) else $error("hit during flush");
  property p_reset; $rose(i_arst_n) |-> o_burst_ready_out_n && o_memory_go_n && !o_data_oe; endproperty
  a_reset: assert property (p_reset) else $error("outputs busy after reset");
  c_hit: cover property ($fell(o_burst_ready_out_n));
  c_miss: cover property ($fell(o_memory_go_n));
  c_backoff_n: cover property (!i_backoff_n ##1 i_backoff_n);
endmodule
bind secondary_cache_bus_control secondary_cache_bus_control_chk i_secondary_cache_bus_control_chk (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_bus(i_bus), .i_backoff_n(i_backoff_n),
  .i_invalidate_all_n(i_invalidate_all_n), .i_module_select_n(i_module_select_n),
  .i_protect_strap_n(i_protect_strap_n), .o_data_oe(o_data_oe),
  .o_hit_cacheable_n(o_hit_cacheable_n), .o_burst_ready_out_n(o_burst_ready_out_n),
  .o_memory_go_n(o_memory_go_n), .o_module_present_n(o_module_present_n));

//--- testbench/mem_model.sv
// memory controller model answering line fills and writes
`timescale 1ns/1ps
module mem_model (
  input wire logic i_clk,
  input wire logic i_go_n,
  input wire logic i_kick,
  input wire logic i_write,
  input wire logic [29:0] i_addr,
  input wire logic i_last_n,
  input wire logic [1:0] i_slow,
  output logic [35:0] o_data,
  output logic o_burst_ready_n,
  output logic o_ready_n,
  output logic o_fill_cacheable_n,
  output logic o_line_protect
);
  logic [29:0] w;
  int k;
  initial begin
    o_data = '1;
    o_burst_ready_n = 1;
    o_ready_n = 1;
    o_fill_cacheable_n = 0;
    o_line_protect = 0;
    forever begin
      @(posedge i_clk);
      if (i_go_n !== 1'b0 && i_kick !== 1'b1) continue;
      #1;
      if (i_write) begin
        o_ready_n = 0;
        @(posedge i_clk);
        #1 o_ready_n = 1;
      end else begin
        for (k = 0; k < 4; k++) begin
          // idle data bus toggles so a stale word never looks valid
          if (i_slow != 2'h0) begin
            o_burst_ready_n = 1;
            repeat (i_slow) begin
              o_data = ~o_data;
              @(posedge i_clk);
              #1;
            end
          end
          w = i_addr ^ 30'(k);
          o_data = {w[3:0] ^ 4'h5, 2'h2, w};
          o_burst_ready_n = 0;
          @(posedge i_clk);
          if (i_last_n === 1'b0) k = 4;
          #1;
        end
        o_burst_ready_n = 1;
        o_data = ~o_data;
      end
    end
  end
endmodule

//--- testbench/secondary_cache_bus_control_test.sv
// self-checking bench for the secondary cache bus control
`timescale 1ns/1ps
module secondary_cache_bus_control_test;
  logic clk = 0, rst_n = 0, backoff_n_n = 1, snp_n = 1, fl_n = 1, sel_n = 0, kick = 0;
  logic [1:0] slow = 0;
  logic nc = 0, wdrv = 0;
  logic [35:0] wdat = '0;
  logic [35:0] dat, mdat, odat;
  logic oe, ck_n, bro_n, go_n, pr_n, br_n, r_n, sk_n, wp;
  cache_pkg::cpu_bus_type bus;
  int fail_count = 0, cmp_count = 0, cyc = 0, beats = 0;
  assign dat = oe ? odat : (wdrv ? wdat : mdat);
  initial forever #50 clk = ~clk;
  always @(posedge clk) if (br_n === 1'b0 || r_n === 1'b0) beats++;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      complete_run();
    end
  end
  secondary_cache_bus_control i_secondary_cache_bus_control (.i_clk(clk), .i_arst_n(rst_n),
    .i_bus(bus), .i_data(dat), .i_cpu_burst_ready_n(br_n), .i_cpu_ready_n(r_n),
    .i_backoff_n(backoff_n_n), .i_snoop_strobe_n(snp_n), .i_invalidate_all_n(fl_n),
    .i_module_select_n(sel_n), .i_fill_cacheable_n(sk_n | nc), .i_line_protect(wp),
    .i_protect_strap_n(1'b1), .o_data(odat), .o_data_oe(oe), .o_hit_cacheable_n(ck_n),
    .o_burst_ready_out_n(bro_n), .o_memory_go_n(go_n), .o_module_present_n(pr_n));
  mem_model i_mem_model (.i_clk(clk), .i_go_n(go_n), .i_kick(kick), .i_write(bus.write),
    .i_addr(bus.addr), .i_last_n(bus.last_transfer_n), .i_slow(slow), .o_data(mdat),
    .o_burst_ready_n(br_n), .o_ready_n(r_n), .o_fill_cacheable_n(sk_n), .o_line_protect(wp));
  task automatic complete_run();
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string n, logic [35:0] e, logic [35:0] s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [35:0] line_word(logic [29:0] a);
    return {a[3:0] ^ 4'h5, 2'h2, a};
  endfunction
  task automatic start(logic [29:0] a, logic wr, logic mem, logic [3:0] be_n = 4'h0);
    bus.addr = a;
    bus.write = wr;
    bus.memory = mem;
    bus.byte_en_n = be_n;
    bus.address_strobe_n = 0;
    tick();
    bus.address_strobe_n = 1;
  endtask
  task automatic rd(logic [29:0] a, logic hit, int last = 4);
    int t = 0;
    beats = 0;
    start(a, 1'b0, 1'b1);
    while (bro_n === 1'b1 && go_n === 1'b1 && t < 4) begin
      tick();
      t++;
    end
    chk("hit", 36'(hit), 36'(!bro_n));
    if (bro_n === 1'b0) begin
      for (int n = 0; n < 4; n++) begin
        chk("hit data", line_word(a ^ 30'(n)), dat);
        chk("cacheable", 36'(n == 0), 36'(ck_n));
        tick();
      end
    end else begin
      while (beats < last && t < 30) begin
        if (beats == last - 1) bus.last_transfer_n = 0;
        tick();
        t++;
      end
      bus.last_transfer_n = 1;
    end
    tick();
  endtask
  task automatic wr(logic [29:0] a, logic [3:0] be_n = 4'h0);
    int t = 0;
    beats = 0;
    bus.last_transfer_n = 0;
    start(a, 1'b1, 1'b1, be_n);
    kick = sel_n;
    tick();
    kick = 0;
    chk("memory go", 36'(sel_n), 36'(go_n));
    while (beats < 1 && t < 10) begin
      tick();
      t++;
    end
    bus.last_transfer_n = 1;
    tick();
  endtask
  task automatic t_fill_hit();
    rd(30'h1000, 0);
    rd(30'h1000, 1);
    rd(30'h1002, 1);
    rd(30'h2104, 0);
    rd(30'h2104, 1);
  endtask
  task automatic t_byte_write();
    wdat = 36'h0_0000_00aa;
    wdrv = 1;
    wr(30'h1000, 4'he);
    wdrv = 0;
    start(30'h1000, 1'b0, 1'b1);
    chk("byte write", 36'h4_8000_10aa, dat);
    chk("present", 36'h0, 36'(pr_n));
    tick(5);
    nc = 1;
    rd(30'h0800, 0);
    nc = 0;
    rd(30'h0800, 0);
  endtask
  task automatic t_ignore();
    start(30'h1000, 1'b0, 1'b0);
    tick(3);
    chk("io go", 36'h1, 36'(go_n));
    chk("io burst", 36'h1, 36'(bro_n));
    wr(30'h3000);
    sel_n = 1;
    wr(30'h3000);
    sel_n = 0;
  endtask
  task automatic t_snoop();
    backoff_n_n = 0;
    bus.addr = 30'h1000;
    tick();
    snp_n = 0;
    tick();
    snp_n = 1;
    tick();
    backoff_n_n = 1;
    tick(2);
    rd(30'h1000, 0);
  endtask
  task automatic t_backoff();
    start(30'h1000, 1'b0, 1'b1);
    tick(2);
    backoff_n_n = 0;
    tick();
    chk("bus released", 36'h0, 36'(oe));
    tick();
    backoff_n_n = 1;
    tick(3);
    rd(30'h1000, 0);
  endtask
  task automatic t_abort();
    rd(30'h0448, 0, 3);
    rd(30'h0448, 0);
  endtask
  task automatic t_flush();
    slow = 1;
    fl_n = 0;
    tick(3);
    rd(30'h2104, 0);
    fl_n = 1;
    slow = 0;
    tick(3);
    rd(30'h1000, 0);
  endtask
  initial begin
    bus = '0;
    bus.address_strobe_n = 1;
    bus.last_transfer_n = 1;
    tick(20);
    rst_n = 1;
    tick(5);
    t_fill_hit();
    t_byte_write();
    t_ignore();
    t_snoop();
    t_backoff();
    t_abort();
    t_flush();
    complete_run();
  end
endmodule
